// [hdl/fbrp_port.sv]
// Burst read port of a parallel flash: pin sequencing, fetch, sleep, registers
//
// Overview of operation
// - Start address taken on first strobed edge
// - Initial latency programmable, two to seven
// - Ready low for delays at start plus 1-3
// - Wrapped 8-word burst stays in group
// - Unwrapped 8-word burst crosses group boundary
// - Ready timing bit zero: ready one early
// - Sleep after stable address; wake on change
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module fbrp_port (
  input  wire logic                         core_clk,
  input  wire logic                         rst_b,
  input  wire logic                         burst_clk,
  input  wire logic                         chip_enable_n,
  input  wire logic                         address_valid_strobe_n,
  input  wire logic                         output_enable_n,
  input  wire logic [fbrp_pkg::ADDR_W-1:0]  addr_in,
  output logic      [fbrp_pkg::WORD_W-1:0]  data_out,
  output logic                              data_oe_n,
  output logic                              ready,
  output logic                              sleep,
  output logic                              array_rd,
  output logic      [fbrp_pkg::ADDR_W-1:0]  array_addr,
  input  wire logic [fbrp_pkg::WORD_W-1:0]  array_rdata,
  input  wire logic [fbrp_pkg::RADDR_W-1:0] reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [31:0]                  reg_rdata
);
  import fbrp_pkg::*;

  logic [2:0]        ws_q;
  fbrp_mode_t        mode_q;
  logic              rtb_q;
  logic [1:0]        bdly_q;
  logic [2:0]        ws_eff;

  logic              bclk_q;
  logic              pin_edge;
  logic              start_evt;
  fbrp_state_t       state_q;
  logic              armed_q;
  logic              plan_q;
  logic              ready_q;
  logic              dlyd_q;
  logic [2:0]        lat_q;
  logic [1:0]        dly_q;
  logic [ADDR_W-1:0] idx_q;
  logic [ADDR_W-1:0] start_q;
  logic [WORD_W-1:0] data_out_q;
  logic              data_oe_n_q;

  logic              pop;
  logic [ADDR_W-1:0] idx_d;
  logic [ADDR_W-1:0] nxt_addr;
  logic              left;
  logic              avail;
  logic              bnd;
  logic              gate;
  logic              plan_d;

  logic              f_on_q;
  logic [ADDR_W-1:0] f_idx_q;
  logic              pend_q;
  logic              array_rd_q;
  logic [ADDR_W-1:0] array_addr_q;
  logic              f_left;
  logic              flush;

  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [WORD_W-1:0] fifo_dout;
  logic [LVL_W-1:0]  fifo_lvl;

  logic [ADDR_W-1:0] addr_prev_q;
  logic [SLP_W-1:0]  stab_q;
  logic              sleep_q;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;

  assign data_out   = data_out_q;
  assign data_oe_n  = data_oe_n_q;
  assign ready      = ready_q;
  assign sleep      = sleep_q;
  assign array_rd   = array_rd_q;
  assign array_addr = array_addr_q;
  assign reg_rdata  = rdata_q;

  // Configuration register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ws_q   <= CFG_WS_RST;
      mode_q <= fbrp_mode_t'(CFG_MODE_RST);
      rtb_q  <= CFG_RTB_RST;
      bdly_q <= CFG_BDLY_RST;
    end else if (reg_wr && reg_addr == REG_CFG) begin
      ws_q   <= reg_wdata[CFG_WS_LSB +: 3];
      mode_q <= fbrp_mode_t'(reg_wdata[CFG_MODE_LSB +: 2]);
      rtb_q  <= reg_wdata[CFG_RTB_BIT];
      bdly_q <= reg_wdata[CFG_BDLY_LSB +: 2];
    end
  end

  assign ws_eff = clamp_ws(ws_q);

  // Burst clock edge detect; inputs are synchronous to core_clk
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bclk_q <= 1'b0;
    end else begin
      bclk_q <= burst_clk;
    end
  end

  assign pin_edge  = burst_clk & ~bclk_q & ~chip_enable_n;
  assign start_evt = pin_edge & ~address_valid_strobe_n & ~armed_q;

  // Strobe stays armed until it or chip enable goes high, so later edges never recapture
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_q <= 1'b0;
    end else if (address_valid_strobe_n || chip_enable_n) begin
      armed_q <= 1'b0;
    end else if (start_evt) begin
      armed_q <= 1'b1;
    end
  end

  // Decision for the coming edge is made one edge early
  always_comb begin
    pop      = pin_edge & plan_q;
    idx_d    = idx_q + {{(ADDR_W-1){1'b0}}, pop};
    nxt_addr = word_addr(start_q, idx_d, mode_q);
    left     = (mode_q != FBRP_WRAP8 && mode_q != FBRP_LIN8) || (idx_d < LIN8_LEN);
    avail    = (fifo_lvl > LVL_W'(1)) || (fifo_lvl == LVL_W'(1) && !pop);
    bnd      = (idx_d >= 24'h000001) && (idx_d <= 24'h000003) &&
               (nxt_addr[3:0] == 4'h0) && !dlyd_q && (bdly_q != 2'h0);
    if (state_q == P_LAT) begin
      gate = (lat_q == 3'h1);
    end else if (dly_q != 2'h0) begin
      gate = (dly_q == 2'h1);
    end else begin
      gate = (state_q == P_DATA);
    end
    plan_d = gate && !bnd && left && avail;
  end

  // Pin-side burst sequencer
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= P_IDLE;
      plan_q  <= 1'b0;
      ready_q <= 1'b0;
      lat_q   <= 3'h0;
      dly_q   <= 2'h0;
      dlyd_q  <= 1'b0;
      idx_q   <= '0;
      start_q <= '0;
    end else if (chip_enable_n) begin
      state_q <= P_IDLE;
      plan_q  <= 1'b0;
      ready_q <= 1'b0;
    end else if (start_evt) begin
      start_q <= addr_in;
      state_q <= P_LAT;
      lat_q   <= 3'(ws_eff - 3'h1);
      plan_q  <= 1'b0;
      ready_q <= 1'b0;
      dly_q   <= 2'h0;
      dlyd_q  <= 1'b0;
      idx_q   <= '0;
    end else if (pin_edge && state_q != P_IDLE) begin
      idx_q  <= idx_d;
      plan_q <= plan_d;
      ready_q <= rtb_q ? pop : plan_d;
      if (lat_q != 3'h0) begin
        lat_q <= 3'(lat_q - 3'h1);
      end
      if (state_q == P_LAT && lat_q == 3'h1) begin
        state_q <= P_DATA;
      end
      if (bnd) begin
        dly_q  <= bdly_q;
        dlyd_q <= 1'b1;
      end else if (dly_q != 2'h0) begin
        dly_q <= 2'(dly_q - 2'h1);
      end
    end
  end

  // Output word changes only on a valid edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_out_q  <= '0;
      data_oe_n_q <= 1'b1;
    end else begin
      data_oe_n_q <= chip_enable_n | output_enable_n;
      if (pop) begin
        data_out_q <= fifo_dout;
      end
    end
  end

  // Array fetch ahead of the pins; stalls when the FIFO nears full
  assign flush  = start_evt | chip_enable_n;
  assign f_left = (mode_q != FBRP_WRAP8 && mode_q != FBRP_LIN8) || (f_idx_q < LIN8_LEN);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      f_on_q       <= 1'b0;
      f_idx_q      <= '0;
      pend_q       <= 1'b0;
      array_rd_q   <= 1'b0;
      array_addr_q <= '0;
    end else if (flush) begin
      f_on_q     <= start_evt;
      f_idx_q    <= '0;
      pend_q     <= 1'b0;
      array_rd_q <= 1'b0;
    end else begin
      pend_q     <= array_rd_q;
      array_rd_q <= 1'b0;
      if (f_on_q && f_left && !array_rd_q && !pend_q &&
          fifo_in_ready && fifo_lvl < LVL_W'(FIFO_DEPTH - 1)) begin
        array_rd_q   <= 1'b1;
        array_addr_q <= word_addr(start_q, f_idx_q, mode_q);
        f_idx_q      <= f_idx_q + 24'h000001;
      end
    end
  end

  fbrp_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) fbrp_fifo_inst (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .flush     (flush),
    .in_valid  (pend_q),
    .in_ready  (fifo_in_ready),
    .in_data   (array_rdata),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_dout),
    .level     (fifo_lvl)
  );

  // Automatic sleep on a stable address
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_prev_q <= '0;
      stab_q      <= '0;
      sleep_q     <= 1'b0;
    end else begin
      addr_prev_q <= addr_in;
      if (addr_in != addr_prev_q) begin
        stab_q  <= '0;
        sleep_q <= 1'b0;
      end else if (stab_q == SLP_W'(SLEEP_CYC)) begin
        sleep_q <= 1'b1;
      end else begin
        stab_q <= SLP_W'(stab_q + 1'b1);
      end
    end
  end

  // Register read; unmapped addresses read zero
  always_comb begin
    rdata_d = 32'h00000000;
    case (reg_addr)
      REG_CFG: begin
        rdata_d[CFG_WS_LSB +: 3]   = ws_q;
        rdata_d[CFG_MODE_LSB +: 2] = mode_q;
        rdata_d[CFG_RTB_BIT]       = rtb_q;
        rdata_d[CFG_BDLY_LSB +: 2] = bdly_q;
      end
      REG_STAT: begin
        rdata_d[ST_SLEEP_BIT]        = sleep_q;
        rdata_d[ST_BUSY_BIT]         = (state_q != P_IDLE);
        rdata_d[ST_EMPTY_BIT]        = !fifo_out_valid;
        rdata_d[ST_LVL_LSB +: LVL_W] = fifo_lvl;
      end
      REG_START: begin
        rdata_d[ADDR_W-1:0] = start_q;
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_addr_first_edge: assert property (
    pin_edge && armed_q && !chip_enable_n |=> $stable(start_q))
    else $error("start address recaptured");
  a_lat_range: assert property (
    ws_eff >= WS_MIN && ws_eff <= WS_MAX)
    else $error("latency out of range");
  a_lat_no_data: assert property (
    state_q == P_LAT && lat_q >= 3'h2 |-> !plan_q)
    else $error("data before latency ends");
  a_delay_ready_low: assert property (
    dly_q > 2'h1 && !chip_enable_n |-> !plan_q)
    else $error("word during delay cycle");
  a_wrap_group: assert property (
    array_rd_q && mode_q == FBRP_WRAP8 |-> array_addr_q[ADDR_W-1:3] == start_q[ADDR_W-1:3])
    else $error("wrapped burst left its group");
  a_lin_order: assert property (
    array_rd_q && mode_q == FBRP_LIN8 |-> array_addr_q == start_q + f_idx_q - 24'h000001)
    else $error("linear burst address wrong");
  a_ready_early: assert property (
    pop && !rtb_q && !$past(chip_enable_n) |-> ready_q)
    else $error("ready not one cycle early");
  a_sleep_entry: assert property (
    $rose(sleep_q) |-> $past(addr_in) == $past(addr_in, 2) && stab_q == SLP_W'(SLEEP_CYC))
    else $error("sleep entered too soon");
  a_hold_word: assert property (
    !pop |=> $stable(data_out_q))
    else $error("word changed without ready");
  a_end_on_ce: assert property (
    chip_enable_n |=> state_q == P_IDLE && !ready_q)
    else $error("burst continued after deselect");

  c_wrap_burst: cover property (pop && mode_q == FBRP_WRAP8 && idx_q == 24'h000007);
  c_delay_insert: cover property (bnd && pin_edge);
  c_sleep: cover property ($rose(sleep_q));
endmodule
`default_nettype wire

// [hdl/fbrp_pkg.sv]
// Constants, types and helpers for the flash burst read port
package fbrp_pkg;
  localparam int ADDR_W     = 24;
  localparam int WORD_W     = 16;
  localparam int RADDR_W    = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int LVL_W      = 5;
  localparam int SLP_W      = 5;

  localparam logic [3:0] REG_CFG   = 4'h0;
  localparam logic [3:0] REG_STAT  = 4'h4;
  localparam logic [3:0] REG_START = 4'h8;

  localparam int CFG_WS_LSB   = 0;
  localparam int CFG_MODE_LSB = 3;
  localparam int CFG_RTB_BIT  = 5;
  localparam int CFG_BDLY_LSB = 8;
  localparam int ST_SLEEP_BIT = 0;
  localparam int ST_BUSY_BIT  = 1;
  localparam int ST_EMPTY_BIT = 2;
  localparam int ST_LVL_LSB   = 4;

  localparam logic [2:0] CFG_WS_RST   = 3'h5;
  localparam logic [1:0] CFG_MODE_RST = 2'h0;
  localparam logic       CFG_RTB_RST  = 1'h1;
  localparam logic [1:0] CFG_BDLY_RST = 2'h1;

  localparam logic [2:0] WS_MIN   = 3'h2;
  localparam logic [2:0] WS_MAX   = 3'h7;
  localparam logic [ADDR_W-1:0] LIN8_LEN = 24'h000008;

  // Automatic sleep: address stable for access time plus margin, rounded up
  localparam int CLK_PERIOD_NS  = 5;
  localparam int T_ACC_NS       = 80;
  localparam int SLEEP_EXTRA_NS = 20;
  localparam int SLEEP_CYC =
    (T_ACC_NS + SLEEP_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {FBRP_CONT, FBRP_WRAP8, FBRP_LIN8, FBRP_RSVD} fbrp_mode_t;
  typedef enum logic [1:0] {P_IDLE, P_LAT, P_DATA} fbrp_state_t;

  function automatic logic [ADDR_W-1:0] word_addr(
    input logic [ADDR_W-1:0] start,
    input logic [ADDR_W-1:0] idx,
    input fbrp_mode_t        mode);
    logic [2:0] low;
    low = start[2:0] + idx[2:0];
    if (mode == FBRP_WRAP8) begin
      word_addr = {start[ADDR_W-1:3], low};
    end else begin
      word_addr = start + idx;
    end
  endfunction

  function automatic logic [2:0] clamp_ws(input logic [2:0] ws);
    clamp_ws = (ws < WS_MIN) ? WS_MIN : ws;
  endfunction
endpackage

// [hdl/fbrp_fifo.sv]
// Word FIFO between array fetch and pin output
`timescale 1ns/100ps
`default_nettype none
module fbrp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  input  wire logic                       flush,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH):0]          level
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign level     = cnt_q;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= PW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_q <= PW'(rd_q + 1'b1);
      end
      cnt_q <= (PW+1)'(cnt_q + push - pop);
    end
  end
endmodule
`default_nettype wire

// [tb/fbrp_host.sv]
// Host controller model that clocks and collects synchronous bursts
`timescale 1ns/100ps
`default_nettype none
module fbrp_host (
  input  wire logic                        core_clk,
  output logic                             burst_clk,
  output logic                             chip_enable_n,
  output logic                             address_valid_strobe_n,
  output logic                             output_enable_n,
  output logic      [fbrp_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [fbrp_pkg::WORD_W-1:0] data_out,
  input  wire logic                        ready
);
  import fbrp_pkg::*;
  logic [15:0] words [0:15];
  int          at [0:15];
  int          nw;
  int          rdy_first;

  initial begin
    burst_clk = 1'b0;
    chip_enable_n = 1'b1;
    address_valid_strobe_n = 1'b1;
    output_enable_n = 1'b1;
    addr_in = 24'h000000;
  end

  task automatic set_addr(input logic [23:0] a);
    @(posedge core_clk);
    addr_in <= a;
  endtask

  // Edge e samples what the device updated after edge e-1
  task automatic burst(input logic [23:0] start, input int hold, input logic rtb);
    logic rdy_p;
    nw = 0;
    rdy_first = -1;
    rdy_p = 1'b0;
    @(posedge core_clk);
    chip_enable_n <= 1'b0;
    output_enable_n <= 1'b0;
    address_valid_strobe_n <= 1'b0;
    addr_in <= start;
    for (int e = 0; e < 32; e++) begin
      repeat (2) @(posedge core_clk);
      burst_clk <= 1'b1;
      if ((rtb ? ready : rdy_p) && nw < 16 && e > 0) begin
        words[nw] = data_out;
        at[nw] = e;
        nw++;
      end
      if (ready && rdy_first < 0) begin
        rdy_first = e;
      end
      rdy_p = ready;
      repeat (2) @(posedge core_clk);
      burst_clk <= 1'b0;
      if (e == 0) begin
        addr_in <= ~start;
      end
      if (e + 1 >= hold) begin
        address_valid_strobe_n <= 1'b1;
      end
    end
    chip_enable_n <= 1'b1;
    output_enable_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [tb/fbrp_port_tb.sv]
// Self-checking bench for the flash burst read port
`timescale 1ns/100ps
`default_nettype none
module fbrp_port_tb;
  import fbrp_pkg::*;
  logic        core_clk, rst_b, burst_clk, chip_enable_n, address_valid_strobe_n;
  logic        output_enable_n, data_oe_n, ready, sleep, array_rd, reg_wr, reg_rd;
  logic [23:0] addr_in, array_addr;
  logic [15:0] data_out, array_rdata;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  int          n_mismatch = 0;
  int          cmp_count = 0;

  fbrp_port fbrp_port_inst (.core_clk(core_clk), .rst_b(rst_b), .burst_clk(burst_clk),
    .chip_enable_n(chip_enable_n), .address_valid_strobe_n(address_valid_strobe_n),
    .output_enable_n(output_enable_n), .addr_in(addr_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .ready(ready), .sleep(sleep), .array_rd(array_rd),
    .array_addr(array_addr), .array_rdata(array_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  fbrp_host fbrp_host_inst (.core_clk(core_clk), .burst_clk(burst_clk),
    .chip_enable_n(chip_enable_n), .address_valid_strobe_n(address_valid_strobe_n),
    .output_enable_n(output_enable_n), .addr_in(addr_in), .data_out(data_out),
    .ready(ready));

  function automatic logic [15:0] wexp(input logic [23:0] a);
    wexp = a[15:0] ^ 16'h5A3C;
  endfunction

  // Array answers one cycle after a read, garbage otherwise
  always_ff @(posedge core_clk) begin
    array_rdata <= array_rd ? wexp(array_addr) : ~array_rdata;
  end

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr_t(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask

  function automatic logic [31:0] cfg(input logic [2:0] ws, input logic [1:0] md,
                                      input logic rtb, input logic [1:0] bd);
    cfg = {22'h0, bd, 2'h0, rtb, md, ws};
  endfunction

  task automatic run(input logic [23:0] s, input int hold, input logic rtb);
    fork
      fbrp_host_inst.burst(s, hold, rtb);
      begin
        repeat (12) @(posedge core_clk);
        #1 chk("data enable in burst", 32'h0, {31'h0, data_oe_n});
      end
    join
    repeat (2) @(posedge core_clk);
    #1 chk("ready after deselect", 32'h0, {31'h0, ready});
    chk("data enable after deselect", 32'h1, {31'h0, data_oe_n});
  endtask

  // Words must follow base upward, optionally wrapping in the 8-word group
  task automatic seq(input logic [23:0] base, input logic wrap, input int n);
    logic [23:0] a;
    chk("word count", n, fbrp_host_inst.nw);
    for (int i = 0; i < n; i++) begin
      a = wrap ? {base[23:3], 3'(base[2:0] + i)} : base + 24'(i);
      chk("burst word", {16'h0, wexp(a)}, {16'h0, fbrp_host_inst.words[i]});
    end
  endtask

  task automatic t_regs;
    reg_wr_t(REG_START, 32'hFFFFFFFF);
    reg_rd_chk(REG_START, 32'h0, "start read only");
    reg_rd_chk(REG_CFG, 32'h00000125, "cfg reset");
    reg_rd_chk(4'hC, 32'h0, "unmapped");
    reg_wr_t(REG_CFG, cfg(3'h6, 2'h2, 1'b0, 2'h3));
    reg_rd_chk(REG_CFG, 32'h00000316, "cfg readback");
    $display("test regs done");
  endtask

  task automatic t_latency;
    int w;
    for (int ws = 1; ws < 8; ws++) begin
      for (int r = 0; r < 2; r++) begin
        w = (ws < 2) ? 2 : ws;
        reg_wr_t(REG_CFG, cfg(ws[2:0], 2'h2, r[0], 2'h0));
        run(24'h000100, 1, r[0]);
        chk("first word edge", w + 1, fbrp_host_inst.at[0]);
        chk("first ready edge", w + r, fbrp_host_inst.rdy_first);
        seq(24'h000100, 1'b0, 8);
        for (int i = 1; i < 8; i++) begin
          chk("word spacing", w + 1 + i, fbrp_host_inst.at[i]);
        end
      end
    end
    $display("test latency done");
  endtask

  task automatic t_modes;
    reg_wr_t(REG_CFG, cfg(3'h2, 2'h1, 1'b1, 2'h0));
    run(24'h000013, 1, 1'b1);
    seq(24'h000013, 1'b1, 8);
    reg_wr_t(REG_CFG, cfg(3'h2, 2'h2, 1'b1, 2'h0));
    run(24'h00001D, 1, 1'b1);
    seq(24'h00001D, 1'b0, 8);
    for (int m = 0; m < 4; m += 3) begin
      reg_wr_t(REG_CFG, cfg(3'h2, m[1:0], 1'b1, 2'h0));
      run(24'h000200, 1, 1'b1);
      seq(24'h000200, 1'b0, 16);
    end
    $display("test modes done");
  endtask

  task automatic t_delay;
    reg_wr_t(REG_CFG, cfg(3'h2, 2'h0, 1'b1, 2'h2));
    run(24'h00010E, 2, 1'b1);
    seq(24'h00010E, 1'b0, 16);
    chk("gap before word 1", 1, fbrp_host_inst.at[1] - fbrp_host_inst.at[0]);
    chk("gap before word 2", 3, fbrp_host_inst.at[2] - fbrp_host_inst.at[1]);
    reg_rd_chk(REG_START, 32'h0000010E, "captured start");
    $display("test delay done");
  endtask

  task automatic t_sleep;
    fbrp_host_inst.set_addr(24'h00ABCD);
    repeat (15) @(posedge core_clk);
    #1 chk("awake early", 32'h0, {31'h0, sleep});
    repeat (10) @(posedge core_clk);
    #1 chk("asleep", 32'h1, {31'h0, sleep});
    reg_rd_chk(REG_STAT, 32'h00000005, "status asleep");
    fbrp_host_inst.set_addr(24'h00ABCE);
    repeat (3) @(posedge core_clk);
    #1 chk("woken", 32'h0, {31'h0, sleep});
    $display("test sleep done");
  endtask

  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    #1 chk("reset outputs", 32'h2, {28'h0, ready, sleep, data_oe_n, array_rd});
    chk("reset read data", 32'h0, reg_rdata);
    repeat (40) @(posedge core_clk);
    t_regs();
    t_latency();
    t_modes();
    t_delay();
    t_sleep();
    end_sim();
  end

  initial begin
    #100us;
    n_mismatch++;
    $display("watchdog expired");
    end_sim();
  end
endmodule
`default_nettype wire
